/* File: rtl/sccm_pkg.sv */
package sccm_pkg;
    // register indexes on the plain register port
    localparam logic [1:0] ADDR_SYS_CLK = 2'h0;
    localparam logic [1:0] ADDR_INT_RC = 2'h1;
    localparam logic [1:0] ADDR_FAST_XTAL = 2'h2;
    localparam logic [1:0] ADDR_SLOW_XTAL = 2'h3;
    // system clock control fields
    localparam int SCC_SEL_LSB = 5;
    localparam int SCC_HS_SRC = 3;
    localparam int SCC_LS_SRC = 2;
    localparam int SCC_HS_IDLE = 1;
    localparam int SCC_LS_IDLE = 0;
    // oscillator control fields
    localparam int OSC_EN = 0;
    localparam int OSC_STABLE = 1;
    localparam int OSC_MODE = 2;
    localparam int RC_FREQ_LSB = 2;
    // reset values
    localparam logic [7:0] SCC_RESET = 8'h00;
    localparam logic [7:0] INT_RC_RESET = 8'h01;
    localparam logic [7:0] FAST_XTAL_RESET = 8'h00;
    localparam logic [7:0] SLOW_XTAL_RESET = 8'h00;
    // clock select codes
    localparam logic [2:0] SEL_SLOW = 3'h7;
    // rc frequency codes, output as MHz value
    localparam logic [3:0] RC_MHZ_4 = 4'h4;
    localparam logic [3:0] RC_MHZ_8 = 4'h8;
    localparam logic [3:0] RC_MHZ_12 = 4'hc;
    // switch delay: 4 system periods plus source margin, in sys_clk cycles
    localparam int SWITCH_SYS_PERIODS = 4;
    localparam int SWITCH_MARGIN_CYCLES = 2;
    localparam int SWITCH_CYCLES = SWITCH_SYS_PERIODS + SWITCH_MARGIN_CYCLES;
    // default stability counts in oscillator cycles
    localparam int STABLE_COUNT_DEFAULT = 16;
    // operating modes
    typedef enum logic [2:0] {
        MODE_FAST,
        MODE_SLOW,
        MODE_SLEEP,
        MODE_STANDBY_SLOW_ONLY,
        MODE_STANDBY_BOTH_OSC,
        MODE_STANDBY_FAST_ONLY
    } sccm_mode_t;
endpackage : sccm_pkg

/* File: rtl/sccm_stable_cnt.sv */
`timescale 1ns/1ps
// counts oscillator ticks after enable or retune, then flags stable
module sccm_stable_cnt #(
    parameter int COUNT = sccm_pkg::STABLE_COUNT_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // oscillator side
    input wire logic osc_en,
    input wire logic restart,
    input wire logic osc_tick,
    // result
    output logic stable
);
    localparam int W = $clog2(COUNT + 1);
    localparam logic [W-1:0] LAST = W'(COUNT);
    logic [W-1:0] cnt;
    logic [W-1:0] next_cnt;
    logic next_stable;

    // restart clears the flag first, counting sets it [RQ23]
    always_comb begin
        next_cnt = cnt;
        next_stable = stable;
        if (!osc_en || restart) begin
            next_cnt = '0;
            next_stable = 1'b0; // [RQ12] [RQ16] [RQ19]
        end else if (osc_tick && !stable) begin
            if (cnt == LAST - W'(1)) begin
                next_stable = 1'b1;
            end
            next_cnt = cnt + W'(1);
        end
    end

    // registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            cnt <= '0;
            stable <= 1'b0;
        end else if (clk_en) begin
            cnt <= next_cnt;
            stable <= next_stable;
        end
    end
endmodule : sccm_stable_cnt

/* File: rtl/sccm_top.sv */
`timescale 1ns/1ps
// What this block does
// RQ1 - sel codes 0-6 give fast clock divided 1..64, code 7 slow clock
// RQ2 - fast clock from internal rc when hs_src_sel 0, crystal when 1
// RQ3 - slow clock from internal rc when ls_src_sel 0, crystal when 1
// RQ4 - halt with both idle enables low gives sleep, slow peripheral clock off
// RQ5 - in sleep slow rc runs only while watchdog enabled
// RQ6 - halt with only slow idle enable high gives slow-only standby
// RQ7 - halt with both idle enables high keeps both oscillators running
// RQ8 - halt with only fast idle enable high keeps fast peripheral clock only
// RQ9 - clock switch completes within bounded delay; software waits for it
// RQ10 - rc frequency code 00 4MHz, 01 8MHz, 10 12MHz, 11 4MHz
// RQ11 - rc output frequency changes only once rc stable flag is set
// RQ12 - enabling or retuning rc clears its stable flag until stable
// RQ13 - software should match rc frequency to factory option
// RQ14 - software sets crystal drive range before enabling crystal
// RQ15 - drive range writes ignored while crystal pins on and crystal enabled
// RQ16 - enabling fast crystal clears its stable flag until stable
// RQ17 - slow crystal speedup bit picks low power or fast start
// RQ18 - speedup bit frozen once slow crystal drives system clock
// RQ19 - enabling slow crystal clears its stable flag until stable
// RQ20 - code 7 moves to slow clock once slow source is stable
// RQ21 - unused register bits read as zero
// RQ22 - in slow mode fast clock follows its oscillator enable bit
// RQ23 - stable flags come from counters restarted on enable or retune
// RQ24 - clock change waits for target stable, then switches cleanly
module sccm_top #(
    parameter int STABLE_COUNT = sccm_pkg::STABLE_COUNT_DEFAULT
) (
    // clock and reset
    input wire logic sys_clk,
    input wire logic sys_rst,
    input wire logic clk_en,
    // register port
    input wire logic [1:0] reg_addr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_wr,
    input wire logic reg_rd,
    output logic [7:0] reg_rdata,
    // cpu and system status
    input wire logic halt_req,
    input wire logic wake_req,
    input wire logic wdt_enabled,
    input wire logic xtal_pins_on,
    // oscillator ticks for stability counting
    input wire logic int_hs_tick,
    input wire logic ext_hs_tick,
    input wire logic ext_ls_tick,
    // oscillator controls
    output logic int_hs_run,
    output logic [3:0] int_hs_mhz,
    output logic ext_hs_run,
    output logic ext_hs_drive_range,
    output logic ext_ls_run,
    output logic ext_ls_speedup,
    output logic int_ls_run,
    // clock selection results
    output logic [2:0] sys_div_log2,
    output logic sys_on_slow,
    output logic hs_from_xtal,
    output logic ls_from_xtal,
    output logic cpu_clk_on,
    output logic hs_periph_on,
    output logic ls_periph_on,
    output logic switch_busy,
    output logic [2:0] op_mode
);
    // register state
    logic [2:0] sys_clk_sel;
    logic hs_src_sel, ls_src_sel, hs_osc_idle_en, ls_osc_idle_en;
    logic [1:0] int_hs_freq_sel;
    logic int_hs_osc_en, ext_hs_osc_en, ext_ls_osc_en;
    logic drive_range, speedup;
    logic [2:0] next_sys_clk_sel;
    logic next_hs_src_sel, next_ls_src_sel;
    logic next_hs_idle, next_ls_idle;
    logic [1:0] next_int_hs_freq_sel;
    logic next_int_hs_osc_en, next_ext_hs_osc_en, next_ext_ls_osc_en;
    logic next_drive_range, next_speedup;
    // stability and restart
    logic int_hs_stable, ext_hs_stable, ext_ls_stable;
    logic rc_restart, hx_restart, lx_restart;
    // active selection, mode and switch timing
    logic [2:0] act_sel, next_act_sel;
    logic act_hs, next_act_hs, act_ls, next_act_ls;
    logic [2:0] sw_cnt, next_sw_cnt;
    sccm_pkg::sccm_mode_t mode, next_mode;
    logic [1:0] rc_freq_applied, next_rc_freq_applied;
    logic [7:0] next_rdata;

    // switch delay load value, cast to the fixed width of the switch counter
    localparam logic [2:0] SW_LOAD = 3'(sccm_pkg::SWITCH_CYCLES);

    // maps the rc code to its frequency
    function automatic logic [3:0] rc_mhz(input logic [1:0] code);
        case (code) // [RQ10]
            2'h1: rc_mhz = sccm_pkg::RC_MHZ_8;
            2'h2: rc_mhz = sccm_pkg::RC_MHZ_12;
            default: rc_mhz = sccm_pkg::RC_MHZ_4;
        endcase
    endfunction : rc_mhz

    // tells whether a chosen source is stable
    function automatic logic src_ready(input logic slow, input logic xtal,
                                       input logic rc_ok,
                                       input logic hx_ok,
                                       input logic lx_ok);
        if (slow) begin
            src_ready = xtal ? lx_ok : 1'b1;
        end else begin
            src_ready = xtal ? hx_ok : rc_ok;
        end
    endfunction : src_ready

    // write decode for the control registers
    always_comb begin
        next_sys_clk_sel = sys_clk_sel;
        next_hs_src_sel = hs_src_sel;
        next_ls_src_sel = ls_src_sel;
        next_hs_idle = hs_osc_idle_en;
        next_ls_idle = ls_osc_idle_en;
        next_int_hs_freq_sel = int_hs_freq_sel;
        next_int_hs_osc_en = int_hs_osc_en;
        next_ext_hs_osc_en = ext_hs_osc_en;
        next_ext_ls_osc_en = ext_ls_osc_en;
        next_drive_range = drive_range;
        next_speedup = speedup;
        rc_restart = 1'b0;
        hx_restart = 1'b0;
        lx_restart = 1'b0;
        if (reg_wr) begin
            case (reg_addr)
                sccm_pkg::ADDR_SYS_CLK: begin
                    next_sys_clk_sel = reg_wdata[sccm_pkg::SCC_SEL_LSB +: 3];
                    next_hs_src_sel = reg_wdata[sccm_pkg::SCC_HS_SRC];
                    next_ls_src_sel = reg_wdata[sccm_pkg::SCC_LS_SRC];
                    next_hs_idle = reg_wdata[sccm_pkg::SCC_HS_IDLE];
                    next_ls_idle = reg_wdata[sccm_pkg::SCC_LS_IDLE];
                end
                sccm_pkg::ADDR_INT_RC: begin
                    next_int_hs_freq_sel =
                        reg_wdata[sccm_pkg::RC_FREQ_LSB +: 2];
                    next_int_hs_osc_en = reg_wdata[sccm_pkg::OSC_EN];
                    rc_restart = (next_int_hs_osc_en && !int_hs_osc_en)
                        || (next_int_hs_freq_sel != int_hs_freq_sel); // [RQ12]
                end
                sccm_pkg::ADDR_FAST_XTAL: begin
                    next_ext_hs_osc_en = reg_wdata[sccm_pkg::OSC_EN];
                    if (!(xtal_pins_on && ext_hs_osc_en)) begin
                        next_drive_range = reg_wdata[sccm_pkg::OSC_MODE]; // [RQ15]
                    end
                    hx_restart = next_ext_hs_osc_en && !ext_hs_osc_en; // [RQ16]
                end
                default: begin
                    next_ext_ls_osc_en = reg_wdata[sccm_pkg::OSC_EN];
                    if (!(act_sel == sccm_pkg::SEL_SLOW && act_ls)) begin
                        next_speedup = reg_wdata[sccm_pkg::OSC_MODE]; // [RQ18]
                    end
                    lx_restart = next_ext_ls_osc_en && !ext_ls_osc_en; // [RQ19]
                end
            endcase
        end
    end

    // control register storage
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            sys_clk_sel <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_SEL_LSB +: 3];
            hs_src_sel <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_HS_SRC];
            ls_src_sel <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_LS_SRC];
            hs_osc_idle_en <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_HS_IDLE];
            ls_osc_idle_en <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_LS_IDLE];
            int_hs_freq_sel <=
                sccm_pkg::INT_RC_RESET[sccm_pkg::RC_FREQ_LSB +: 2];
            int_hs_osc_en <= sccm_pkg::INT_RC_RESET[sccm_pkg::OSC_EN];
            ext_hs_osc_en <= sccm_pkg::FAST_XTAL_RESET[sccm_pkg::OSC_EN];
            drive_range <= sccm_pkg::FAST_XTAL_RESET[sccm_pkg::OSC_MODE];
            ext_ls_osc_en <= sccm_pkg::SLOW_XTAL_RESET[sccm_pkg::OSC_EN];
            speedup <= sccm_pkg::SLOW_XTAL_RESET[sccm_pkg::OSC_MODE];
        end else if (clk_en) begin
            sys_clk_sel <= next_sys_clk_sel;
            hs_src_sel <= next_hs_src_sel;
            ls_src_sel <= next_ls_src_sel;
            hs_osc_idle_en <= next_hs_idle;
            ls_osc_idle_en <= next_ls_idle;
            int_hs_freq_sel <= next_int_hs_freq_sel;
            int_hs_osc_en <= next_int_hs_osc_en;
            ext_hs_osc_en <= next_ext_hs_osc_en;
            drive_range <= next_drive_range;
            ext_ls_osc_en <= next_ext_ls_osc_en;
            speedup <= next_speedup;
        end
    end

    // stability counters, one per gated oscillator
    logic [2:0] osc_en_v, restart_v, tick_v, stable_v;
    assign osc_en_v = {ext_ls_osc_en, ext_hs_osc_en, int_hs_osc_en};
    assign restart_v = {lx_restart, hx_restart, rc_restart};
    assign tick_v = {ext_ls_tick, ext_hs_tick, int_hs_tick};
    assign {ext_ls_stable, ext_hs_stable, int_hs_stable} = stable_v;
    for (genvar g = 0; g < 3; g++) begin : g_stable
        sccm_stable_cnt #(.COUNT(STABLE_COUNT)) u_cnt (
            .sys_clk(sys_clk),
            .sys_rst(sys_rst),
            .clk_en(clk_en),
            .osc_en(osc_en_v[g]),
            .restart(restart_v[g]),
            .osc_tick(tick_v[g]),
            .stable(stable_v[g])
        );
    end

    // glitch-free change over: hold old source until target is stable
    always_comb begin
        next_act_sel = act_sel;
        next_act_hs = act_hs;
        next_act_ls = act_ls;
        next_sw_cnt = sw_cnt;
        next_rc_freq_applied = rc_freq_applied;
        if (sys_clk_sel != act_sel || hs_src_sel != act_hs
                || ls_src_sel != act_ls) begin
            if (src_ready(sys_clk_sel == sccm_pkg::SEL_SLOW,
                    (sys_clk_sel == sccm_pkg::SEL_SLOW) ? ls_src_sel
                                                        : hs_src_sel,
                    int_hs_stable, ext_hs_stable, ext_ls_stable)) begin
                if (sw_cnt == 3'h0) begin
                    next_sw_cnt = SW_LOAD; // [RQ9]
                end else if (sw_cnt == 3'h1) begin
                    next_act_sel = sys_clk_sel; // [RQ1] [RQ20] [RQ24]
                    next_act_hs = hs_src_sel; // [RQ2]
                    next_act_ls = ls_src_sel; // [RQ3]
                    next_sw_cnt = 3'h0;
                end else begin
                    next_sw_cnt = sw_cnt - 3'h1;
                end
            end else begin
                next_sw_cnt = 3'h0; // [RQ24]
            end
        end else begin
            next_sw_cnt = 3'h0;
        end
        if (int_hs_stable) begin
            next_rc_freq_applied = int_hs_freq_sel; // [RQ11]
        end
    end

    // halt and wake decide the operating mode
    always_comb begin
        next_mode = mode;
        case (mode)
            sccm_pkg::MODE_FAST, sccm_pkg::MODE_SLOW: begin
                if (halt_req) begin
                    case ({hs_osc_idle_en, ls_osc_idle_en})
                        2'h0: next_mode = sccm_pkg::MODE_SLEEP; // [RQ4]
                        2'h1: next_mode =
                            sccm_pkg::MODE_STANDBY_SLOW_ONLY; // [RQ6]
                        2'h3: next_mode =
                            sccm_pkg::MODE_STANDBY_BOTH_OSC; // [RQ7]
                        default: next_mode =
                            sccm_pkg::MODE_STANDBY_FAST_ONLY; // [RQ8]
                    endcase
                end else begin
                    next_mode = (act_sel == sccm_pkg::SEL_SLOW)
                        ? sccm_pkg::MODE_SLOW : sccm_pkg::MODE_FAST;
                end
            end
            default: begin
                if (wake_req) begin
                    next_mode = (act_sel == sccm_pkg::SEL_SLOW)
                        ? sccm_pkg::MODE_SLOW : sccm_pkg::MODE_FAST;
                end
            end
        endcase
    end

    // read data, unused bits zero
    always_comb begin
        next_rdata = 8'h00; // [RQ21]
        if (reg_rd) begin
            case (reg_addr)
                sccm_pkg::ADDR_SYS_CLK: next_rdata = {sys_clk_sel, 1'b0,
                    hs_src_sel, ls_src_sel, hs_osc_idle_en, ls_osc_idle_en};
                sccm_pkg::ADDR_INT_RC: next_rdata = {4'h0, int_hs_freq_sel,
                    int_hs_stable, int_hs_osc_en};
                sccm_pkg::ADDR_FAST_XTAL: next_rdata = {5'h00, drive_range,
                    ext_hs_stable, ext_hs_osc_en};
                default: next_rdata = {5'h00, speedup, ext_ls_stable,
                    ext_ls_osc_en};
            endcase
        end
    end

    // selection, mode and read registers
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            act_sel <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_SEL_LSB +: 3];
            act_hs <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_HS_SRC];
            act_ls <= sccm_pkg::SCC_RESET[sccm_pkg::SCC_LS_SRC];
            sw_cnt <= 3'h0;
            mode <= sccm_pkg::MODE_FAST;
            rc_freq_applied <=
                sccm_pkg::INT_RC_RESET[sccm_pkg::RC_FREQ_LSB +: 2];
            reg_rdata <= 8'h00;
        end else if (clk_en) begin
            act_sel <= next_act_sel;
            act_hs <= next_act_hs;
            act_ls <= next_act_ls;
            sw_cnt <= next_sw_cnt;
            mode <= next_mode;
            rc_freq_applied <= next_rc_freq_applied;
            reg_rdata <= next_rdata;
        end
    end

    // registered clock and oscillator outputs
    always_ff @(posedge sys_clk) begin
        if (sys_rst) begin
            int_hs_run <= 1'b0;
            int_hs_mhz <= sccm_pkg::RC_MHZ_4;
            ext_hs_run <= 1'b0;
            ext_hs_drive_range <= 1'b0;
            ext_ls_run <= 1'b0;
            ext_ls_speedup <= 1'b0;
            int_ls_run <= 1'b1;
            sys_div_log2 <= 3'h0;
            sys_on_slow <= 1'b0;
            hs_from_xtal <= 1'b0;
            ls_from_xtal <= 1'b0;
            cpu_clk_on <= 1'b1;
            hs_periph_on <= 1'b1;
            ls_periph_on <= 1'b1;
            switch_busy <= 1'b0;
            op_mode <= 3'h0;
        end else if (clk_en) begin
            // fast oscillators follow enables, off in sleep and slow standby
            int_hs_run <= int_hs_osc_en && mode != sccm_pkg::MODE_SLEEP
                && mode != sccm_pkg::MODE_STANDBY_SLOW_ONLY; // [RQ22]
            ext_hs_run <= ext_hs_osc_en && mode != sccm_pkg::MODE_SLEEP
                && mode != sccm_pkg::MODE_STANDBY_SLOW_ONLY;
            int_hs_mhz <= rc_mhz(rc_freq_applied); // [RQ11]
            ext_hs_drive_range <= drive_range;
            ext_ls_speedup <= speedup; // [RQ17]
            ext_ls_run <= ext_ls_osc_en;
            // slow rc kept for watchdog only while sleeping
            int_ls_run <= (mode == sccm_pkg::MODE_SLEEP)
                ? wdt_enabled : 1'b1; // [RQ5]
            sys_div_log2 <= (act_sel == sccm_pkg::SEL_SLOW) ? 3'h0
                : act_sel; // [RQ1]
            sys_on_slow <= act_sel == sccm_pkg::SEL_SLOW;
            hs_from_xtal <= act_hs;
            ls_from_xtal <= act_ls;
            cpu_clk_on <= next_mode == sccm_pkg::MODE_FAST
                || next_mode == sccm_pkg::MODE_SLOW;
            hs_periph_on <= next_mode != sccm_pkg::MODE_SLEEP // [RQ8]
                && next_mode != sccm_pkg::MODE_STANDBY_SLOW_ONLY;
            ls_periph_on <= next_mode != sccm_pkg::MODE_SLEEP // [RQ4]
                && next_mode != sccm_pkg::MODE_STANDBY_FAST_ONLY;
            switch_busy <= next_sw_cnt != 3'h0
                || sys_clk_sel != next_act_sel;
            op_mode <= 3'(next_mode);
        end
    end
endmodule : sccm_top

/* File: test/sccm_top_props.sv */
`timescale 1ns/1ps
// timing relations watched at the top module's ports
module sccm_top_props (
    // clock and reset
    input logic sys_clk,
    input logic sys_rst,
    // register port
    input logic [1:0] reg_addr,
    input logic reg_rd,
    input logic [7:0] reg_rdata,
    // system status
    input logic wdt_enabled,
    input logic xtal_pins_on,
    // oscillator and clock outputs
    input logic [3:0] int_hs_mhz,
    input logic ext_hs_run,
    input logic ext_hs_drive_range,
    input logic ext_ls_speedup,
    input logic int_ls_run,
    input logic [2:0] sys_div_log2,
    input logic sys_on_slow,
    input logic ls_from_xtal,
    input logic cpu_clk_on,
    input logic hs_periph_on,
    input logic ls_periph_on,
    input logic [2:0] op_mode
);
    // single clock domain for every property
    default clocking cb @(posedge sys_clk);
    endclocking
    default disable iff (sys_rst);

    // read data stands one cycle only after a read strobe
    read_zero_a: assert property (!$past(reg_rd) |-> reg_rdata == 8'h00)
        else $error("read data outside read slot");
    unused_bit_a: assert property (
        $past(reg_rd) && $past(reg_addr) == 2'h0 |-> !reg_rdata[4])
        else $error("unused control bit reads one");
    rc_upper_a: assert property (
        $past(reg_rd) && $past(reg_addr) != 2'h0 |-> reg_rdata[7:4] == 4'h0)
        else $error("oscillator upper bits read nonzero");
    xtal_upper_a: assert property (
        $past(reg_rd) && $past(reg_addr[1]) |-> reg_rdata[7:3] == 5'h00)
        else $error("crystal upper bits read nonzero");
    // clock selection and frequency encodings
    rc_freq_a: assert property (
        int_hs_mhz == 4'h4 || int_hs_mhz == 4'h8 || int_hs_mhz == 4'hc)
        else $error("rc frequency not a legal value");
    slow_div_a: assert property (sys_on_slow |-> sys_div_log2 == 3'h0)
        else $error("divider active on slow clock");
    // halted modes and their clocks
    sleep_clocks_a: assert property (
        op_mode == 3'h2 |-> !cpu_clk_on && !ls_periph_on && !hs_periph_on)
        else $error("clock running in sleep");
    sleep_int_ls_rc_osc_a: assert property (
        op_mode == 3'h2 && $past(op_mode) == 3'h2 && $stable(wdt_enabled)
        |-> int_ls_run == wdt_enabled)
        else $error("slow rc not following watchdog in sleep");
    idle_slow_a: assert property (
        op_mode == 3'h3 |-> !cpu_clk_on && ls_periph_on)
        else $error("slow-only standby clocks wrong");
    idle_both_a: assert property (
        op_mode == 3'h4 |-> !cpu_clk_on && ls_periph_on && hs_periph_on)
        else $error("both-osc standby clocks wrong");
    idle_fast_a: assert property (
        op_mode == 3'h5 |-> !cpu_clk_on && hs_periph_on && !ls_periph_on)
        else $error("fast-only standby clocks wrong");
    // write locks
    speedup_freeze_a: assert property (
        sys_on_slow && ls_from_xtal && $past(sys_on_slow && ls_from_xtal)
        |-> $stable(ext_ls_speedup))
        else $error("speedup changed on slow crystal clock");
    range_lock_a: assert property (
        xtal_pins_on && ext_hs_run && $past(xtal_pins_on && ext_hs_run)
        |-> $stable(ext_hs_drive_range))
        else $error("drive range changed while locked");
endmodule : sccm_top_props

bind sccm_top sccm_top_props u_props (.*);

/* File: test/test_system_clock_mode_control.sv */
`timescale 1ns/1ps
module test_system_clock_mode_control;
    // stimulus and observed signals
    logic sys_clk = 1'b0;
    logic sys_rst = 1'b1;
    logic clk_en = 1'b1;
    logic tick = 1'b1;
    logic [1:0] reg_addr = 2'h0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic halt_req = 1'b0;
    logic wake_req = 1'b0;
    logic wdt_enabled = 1'b0;
    logic xtal_pins_on = 1'b0;
    logic [7:0] reg_rdata;
    logic [3:0] int_hs_mhz;
    logic [2:0] sys_div_log2, op_mode;
    logic int_hs_run, ext_hs_run, ext_hs_drive_range, ext_ls_run;
    logic ext_ls_speedup, int_ls_run, sys_on_slow, hs_from_xtal;
    logic ls_from_xtal, cpu_clk_on, hs_periph_on, ls_periph_on, switch_busy;
    logic [7:0] rd;
    int n_errors = 0;
    int n_checks = 0;

    // short stability count keeps the run brief
    sccm_top #(.STABLE_COUNT(4)) dut (
        .*,
        .int_hs_tick(tick),
        .ext_hs_tick(tick),
        .ext_ls_tick(tick)
    );

    // 40 MHz clock
    initial begin
        forever #12.5 sys_clk = ~sys_clk;
    end

    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        n_checks++;
        if (got !== exp) begin
            n_errors++;
            $display("BAD %0t got %h expected %h", $time, got, exp);
        end
    endtask : chk

    task automatic idle(input int n);
        repeat (n) @(posedge sys_clk);
    endtask : idle

    task automatic wr(input logic [1:0] a, input logic [7:0] d);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge sys_clk);
        reg_wr <= 1'b0;
    endtask : wr

    // read data is taken in the single cycle after the strobe
    task automatic rdr(input logic [1:0] a, input logic [7:0] exp);
        @(posedge sys_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge sys_clk);
        reg_rd <= 1'b0;
        #1 rd = reg_rdata;
        chk(rd, exp);
    endtask : rdr

    // waits for the clock switch under a bound, then checks the bound
    task automatic settle;
        int k;
        k = 0;
        idle(3);
        while (switch_busy !== 1'b0 && k < 40) begin
            @(posedge sys_clk);
            k++;
        end
        #1 chk({7'h0, k > 9}, 8'h00);
    endtask : settle

    task automatic t_reset;
        rdr(sccm_pkg::ADDR_SYS_CLK, sccm_pkg::SCC_RESET);
        rdr(sccm_pkg::ADDR_FAST_XTAL, sccm_pkg::FAST_XTAL_RESET);
        rdr(sccm_pkg::ADDR_SLOW_XTAL, sccm_pkg::SLOW_XTAL_RESET);
        chk({4'h0, int_hs_mhz}, 8'h04);
    endtask : t_reset

    task automatic t_rc;
        logic [7:0] mhz [4] = '{8'h04, 8'h08, 8'h0c, 8'h04};
        wr(sccm_pkg::ADDR_INT_RC, 8'h05);
        rdr(sccm_pkg::ADDR_INT_RC, 8'h05);
        chk({4'h0, int_hs_mhz}, 8'h04);
        idle(20);
        rdr(sccm_pkg::ADDR_INT_RC, 8'h07);
        chk({4'h0, int_hs_mhz}, 8'h08);
        for (int i = 0; i < 4; i++) begin
            wr(sccm_pkg::ADDR_INT_RC, {4'h0, i[1:0], 2'b01});
            idle(20);
            chk({4'h0, int_hs_mhz}, mhz[i]);
        end
    endtask : t_rc

    task automatic t_fast;
        xtal_pins_on <= 1'b1;
        wr(sccm_pkg::ADDR_FAST_XTAL, 8'h01);
        rdr(sccm_pkg::ADDR_FAST_XTAL, 8'h01);
        idle(20);
        rdr(sccm_pkg::ADDR_FAST_XTAL, 8'h03);
        wr(sccm_pkg::ADDR_FAST_XTAL, 8'h05);
        rdr(sccm_pkg::ADDR_FAST_XTAL, 8'h03);
        @(posedge sys_clk);
        xtal_pins_on <= 1'b0;
        wr(sccm_pkg::ADDR_FAST_XTAL, 8'h05);
        rdr(sccm_pkg::ADDR_FAST_XTAL, 8'h07);
        chk({7'h0, ext_hs_drive_range}, 8'h01);
        for (int i = 0; i < 7; i++) begin
            wr(sccm_pkg::ADDR_SYS_CLK, {i[2:0], 5'h08});
            settle();
            chk({4'h0, sys_on_slow, sys_div_log2}, i[7:0]);
            chk({7'h0, hs_from_xtal}, 8'h01);
        end
    endtask : t_fast

    task automatic t_slow;
        wr(sccm_pkg::ADDR_SLOW_XTAL, 8'h05);
        rdr(sccm_pkg::ADDR_SLOW_XTAL, 8'h05);
        idle(20);
        rdr(sccm_pkg::ADDR_SLOW_XTAL, 8'h07);
        wr(sccm_pkg::ADDR_SYS_CLK, 8'he4);
        settle();
        chk({4'h0, sys_on_slow, sys_div_log2}, 8'h08);
        chk({7'h0, ls_from_xtal}, 8'h01);
        wr(sccm_pkg::ADDR_SLOW_XTAL, 8'h01);
        rdr(sccm_pkg::ADDR_SLOW_XTAL, 8'h07);
        wr(sccm_pkg::ADDR_SYS_CLK, 8'he0);
        settle();
        chk({6'h0, ls_from_xtal, hs_from_xtal}, 8'h00);
        wr(sccm_pkg::ADDR_FAST_XTAL, 8'h04);
        idle(4);
        chk({7'h0, ext_hs_run}, 8'h00);
        wr(sccm_pkg::ADDR_SYS_CLK, 8'h00);
        settle();
        chk({7'h0, sys_on_slow}, 8'h00);
    endtask : t_slow

    // each idle-bit pair, sleep twice with and without watchdog
    task automatic t_halt;
        logic [1:0] ib [5] = '{2'h0, 2'h1, 2'h3, 2'h2, 2'h0};
        logic [7:0] md [5] = '{8'h02, 8'h03, 8'h04, 8'h05, 8'h02};
        for (int i = 0; i < 5; i++) begin
            wr(sccm_pkg::ADDR_SYS_CLK, {6'h00, ib[i]});
            wdt_enabled <= (i == 4);
            halt_req <= 1'b1;
            @(posedge sys_clk);
            halt_req <= 1'b0;
            idle(3);
            chk({5'h0, op_mode}, md[i]);
            chk({4'h0, cpu_clk_on, hs_periph_on, ls_periph_on, int_ls_run},
                {5'h0, ib[i], i != 0});
            wake_req <= 1'b1;
            @(posedge sys_clk);
            wake_req <= 1'b0;
            idle(3);
            chk({5'h0, op_mode}, 8'h00);
        end
    endtask : t_halt

    task automatic test_done;
        $display("checks %0d errors %0d", n_checks, n_errors);
        if (n_errors == 0 && n_checks > 0) begin
            $display("All checks passed");
        end else begin
            $display("Checks failed");
        end
        $finish;
    endtask : test_done

    // watchdog far beyond the expected run length
    initial begin
        #500000;
        n_errors++;
        test_done();
    end

    // reset, then the scenarios
    initial begin
        idle(20);
        sys_rst <= 1'b0;
        t_reset();
        t_rc();
        t_fast();
        t_slow();
        t_halt();
        test_done();
    end
endmodule : test_system_clock_mode_control
